// ---- logic/serial_register_slave_port.sv ----
// Two-wire register target: link logic on the link clock, storage on i_clk
//
// Operation
// - Answer only own address, LSB from strap
// - Strap low 1101000, strap high 1101001
// - Target only; clock only ever held low
// - Data fall with clock high is START
// - Data rise with clock high is STOP
// - Repeated START keeps bus busy, restarts addressing
// - Bytes are eight bits, MSB first, unlimited
// - Receiver pulls data low on ninth clock
// - Address and direction bit, then target acknowledges
// - Data changes only while clock is low
// - Write: address, index, data, each acknowledged, stored
// - Burst write advances index per byte
// - Read: write index, repeated START, read address
// - Controller acknowledge requests next register byte
// - Not-acknowledge ends read; data line released
// - Disable bit stops two-wire mode for good
// - Pins shared with four-wire port at 1MHz
`timescale 1ns/1ps
module serial_register_slave_port (
    // Register side clock, and reset for both domains
    input wire logic i_clk,
    input wire logic i_rst,
    // Link clock
    input wire logic i_link_clk,
    // Two-wire pins
    input wire logic i_scl,
    output logic o_scl_out,
    output logic o_scl_oe,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_addr_lsb_strap,
    // Configuration
    input wire logic i_twowire_port_disable,
    // Register write report
    output twowire_pkg::reg_wr_t o_reg_wr
);
    import twowire_pkg::*;

    // Link domain synchronisers, state and decoded bus events
    logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
    logic strap_s1, strap_s2, dis_s1, dis_s2, ack_s1, ack_s2;
    logic disabled, next_disabled;
    link_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] shreg, next_shreg, tx_shreg, next_tx_shreg;
    logic [INDEX_W-1:0] reg_index, next_reg_index;
    logic rw, next_rw, idx_phase, next_idx_phase, master_ack, next_master_ack;
    logic sda_oe, next_sda_oe, scl_oe, next_scl_oe;
    logic req_tgl, next_req_tgl, pin_low;
    reg_req_t req, next_req;
    logic scl_rise, scl_fall, start_det, stop_det, addr_match;
    // Core domain
    logic req_s1, req_s2, req_seen, next_req_seen, ack_tgl, next_ack_tgl;
    core_state_t cstate, next_cstate;
    logic [DATA_W-1:0] rdata, next_rdata, mem_rdata;
    reg_wr_t wr, next_wr;
    logic req_new;

    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
            dis_s1 <= 1'b0;
            dis_s2 <= 1'b0;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            scl_s1 <= i_scl;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= i_sda;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
            strap_s1 <= i_addr_lsb_strap;
            strap_s2 <= strap_s1;
            dis_s1 <= i_twowire_port_disable;
            dis_s2 <= dis_s1;
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
        end
    end

    assign scl_rise = scl_s2 && !scl_d;
    assign scl_fall = !scl_s2 && scl_d;
    assign start_det = scl_s2 && scl_d && sda_d && !sda_s2;
    assign stop_det = scl_s2 && scl_d && !sda_d && sda_s2;
    assign addr_match = (shreg[7:1] == {TARGET_ADDR_HI, strap_s2});

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_tx_shreg = tx_shreg;
        next_reg_index = reg_index;
        next_rw = rw;
        next_idx_phase = idx_phase;
        next_master_ack = master_ack;
        next_sda_oe = sda_oe;
        next_scl_oe = scl_oe;
        next_req_tgl = req_tgl;
        next_req = req;
        next_disabled = disabled || dis_s2;
        if (next_disabled) begin
            // Pins left to the four-wire port
            next_state = ST_IDLE;
            next_sda_oe = 1'b0;
            next_scl_oe = 1'b0;
        end else if (start_det) begin
            next_state = ST_ADDR;
            next_cnt = 4'h0;
            next_sda_oe = 1'b0;
            next_scl_oe = 1'b0;
        end else if (stop_det) begin
            next_state = ST_IDLE;
            next_sda_oe = 1'b0;
            next_scl_oe = 1'b0;
        end else begin
            case (state)
                ST_ADDR, ST_RX: begin
                    if (scl_rise && cnt != BITS_PER_BYTE) begin
                        next_shreg = {shreg[6:0], sda_s2};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == BITS_PER_BYTE) begin
                        if (state == ST_ADDR) begin
                            if (addr_match) begin
                                next_sda_oe = 1'b1;
                                next_rw = shreg[0];
                                next_state = ST_ACK_ADDR;
                            end else begin
                                next_state = ST_IGNORE;
                            end
                        end else begin
                            next_sda_oe = 1'b1;
                            next_state = ST_ACK_RX;
                            if (idx_phase) begin
                                next_reg_index = shreg;
                                next_idx_phase = 1'b0;
                            end else begin
                                next_req = '{write: 1'b1, index: reg_index, data: shreg};
                                next_req_tgl = !req_tgl;
                                next_reg_index = reg_index + 8'h01;
                            end
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        next_sda_oe = 1'b0;
                        next_cnt = 4'h0;
                        if (rw == DIR_READ) begin
                            next_req = '{write: 1'b0, index: reg_index, data: 8'h00};
                            next_req_tgl = !req_tgl;
                            next_scl_oe = 1'b1;
                            next_state = ST_WAIT;
                        end else begin
                            next_idx_phase = 1'b1;
                            next_state = ST_RX;
                        end
                    end
                end
                ST_ACK_RX: begin
                    if (scl_fall) begin
                        next_sda_oe = 1'b0;
                        next_cnt = 4'h0;
                        next_state = ST_RX;
                        if (req_tgl != ack_s2) begin
                            next_scl_oe = 1'b1;
                            next_state = ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (req_tgl == ack_s2) begin
                        next_scl_oe = 1'b0;
                        next_cnt = 4'h0;
                        if (rw == DIR_READ) begin
                            next_tx_shreg = rdata;
                            next_sda_oe = !rdata[7];
                            next_reg_index = reg_index + 8'h01;
                            next_state = ST_TX;
                        end else begin
                            next_state = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (cnt == LAST_TX_BIT) begin
                            next_sda_oe = 1'b0;
                            next_state = ST_ACK_TX;
                        end else begin
                            next_tx_shreg = {tx_shreg[6:0], 1'b0};
                            next_sda_oe = !tx_shreg[6];
                            next_cnt = cnt + 4'h1;
                        end
                    end
                end
                ST_ACK_TX: begin
                    if (scl_rise) begin
                        next_master_ack = !sda_s2;
                    end else if (scl_fall) begin
                        if (master_ack) begin
                            next_req = '{write: 1'b0, index: reg_index, data: 8'h00};
                            next_req_tgl = !req_tgl;
                            next_scl_oe = 1'b1;
                            next_state = ST_WAIT;
                        end else begin
                            next_state = ST_IGNORE;
                        end
                    end
                end
                default: begin
                    next_sda_oe = 1'b0;
                    next_scl_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            tx_shreg <= 8'h00;
            reg_index <= 8'h00;
            rw <= 1'b0;
            idx_phase <= 1'b0;
            master_ack <= 1'b0;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            req_tgl <= 1'b0;
            req <= '0;
            disabled <= 1'b0;
            pin_low <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shreg <= next_shreg;
            tx_shreg <= next_tx_shreg;
            reg_index <= next_reg_index;
            rw <= next_rw;
            idx_phase <= next_idx_phase;
            master_ack <= next_master_ack;
            sda_oe <= next_sda_oe;
            scl_oe <= next_scl_oe;
            req_tgl <= next_req_tgl;
            req <= next_req;
            disabled <= next_disabled;
            pin_low <= 1'b0;
        end
    end

    assign o_sda_oe = sda_oe;
    assign o_scl_oe = scl_oe;
    assign o_sda_out = pin_low;
    assign o_scl_out = pin_low;

    // Core side of the request handshake
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
        end else begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
        end
    end

    assign req_new = (req_s2 != req_seen);

    always_comb begin
        next_cstate = cstate;
        next_req_seen = req_seen;
        next_ack_tgl = ack_tgl;
        next_rdata = rdata;
        next_wr = '{strobe: 1'b0, index: wr.index, data: wr.data};
        case (cstate)
            C_IDLE: begin
                if (req_new) begin
                    next_req_seen = req_s2;
                    if (req.write) begin
                        next_wr = '{strobe: 1'b1, index: req.index, data: req.data};
                        next_ack_tgl = !ack_tgl;
                    end else begin
                        next_cstate = C_READ;
                    end
                end
            end
            C_READ: begin
                next_rdata = mem_rdata;
                next_ack_tgl = !ack_tgl;
                next_cstate = C_IDLE;
            end
            default: next_cstate = C_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cstate <= C_IDLE;
            req_seen <= 1'b0;
            ack_tgl <= 1'b0;
            rdata <= 8'h00;
            wr <= '0;
        end else begin
            cstate <= next_cstate;
            req_seen <= next_req_seen;
            ack_tgl <= next_ack_tgl;
            rdata <= next_rdata;
            wr <= next_wr;
        end
    end

    assign o_reg_wr = wr;

    reg_store #(.ADDR_W(INDEX_W), .DATA_W(DATA_W)) u_store (
        .i_clk(i_clk),
        .i_we(cstate == C_IDLE && req_new && req.write),
        .i_addr(req.index),
        .i_wdata(req.data),
        .o_rdata(mem_rdata)
    );

    // Checks on the link and core domains
    chk_clock_hold_only: assert property (@(posedge i_link_clk) disable iff (i_rst)
        o_scl_oe |-> state == ST_WAIT && !o_scl_out) else $error("clock held outside wait");
    chk_start_addr: assert property (@(posedge i_link_clk) disable iff (i_rst)
        start_det && !disabled && !dis_s2 |=> state == ST_ADDR && cnt == 4'h0)
        else $error("start not taken");
    chk_stop_free: assert property (@(posedge i_link_clk) disable iff (i_rst)
        stop_det && !start_det |=> state == ST_IDLE && !sda_oe && !scl_oe)
        else $error("stop did not free bus");
    chk_match_ack: assert property (@(posedge i_link_clk) disable iff (i_rst)
        state == ST_ADDR && scl_fall && cnt == BITS_PER_BYTE && addr_match && !start_det
        && !stop_det
        && !dis_s2 |=> state == ST_ACK_ADDR && sda_oe) else $error("own address not acked");
    chk_mismatch_quiet: assert property (@(posedge i_link_clk) disable iff (i_rst)
        state == ST_IGNORE |-> !sda_oe && !scl_oe) else $error("drive in ignore");
    chk_sda_clock_low: assert property (@(posedge i_link_clk) disable iff (i_rst)
        $changed(sda_oe) |-> !$past(scl_s2) || $past(start_det || stop_det || state == ST_WAIT))
        else $error("data moved with clock high");
    chk_burst_incr: assert property (@(posedge i_link_clk) disable iff (i_rst)
        state == ST_RX && !idx_phase && scl_fall && cnt == BITS_PER_BYTE && !start_det
        && !stop_det
        && !dis_s2 |=> reg_index == $past(reg_index) + 8'h01 && req.write)
        else $error("index not advanced");
    chk_nack_release: assert property (@(posedge i_link_clk) disable iff (i_rst)
        state == ST_ACK_TX && scl_fall && !master_ack && !start_det && !stop_det && !dis_s2
        |=> state == ST_IGNORE ##1 !sda_oe) else $error("nack not honoured");
    chk_disable_idle: assert property (@(posedge i_link_clk) disable iff (i_rst)
        disabled |-> state == ST_IDLE && !sda_oe && !scl_oe) else $error("active while off");
    chk_write_store: assert property (@(posedge i_clk) disable iff (i_rst)
        cstate == C_IDLE && req_new && req.write |=> wr.strobe && wr.index == $past(req.index)
        ##1 !wr.strobe) else $error("write not reported");
    chk_read_reply: assert property (@(posedge i_clk) disable iff (i_rst)
        cstate == C_IDLE && req_new && !req.write |=> cstate == C_READ ##1 $changed(ack_tgl))
        else $error("read not answered");

    cov_write: cover property (@(posedge i_clk) disable iff (i_rst) wr.strobe);
    cov_stretch: cover property (@(posedge i_link_clk) disable iff (i_rst) o_scl_oe);
    cov_burst_read: cover property (@(posedge i_link_clk) disable iff (i_rst)
        state == ST_ACK_TX && scl_fall && master_ack);
    cov_nack: cover property (@(posedge i_link_clk) disable iff (i_rst)
        state == ST_ACK_TX && scl_fall && !master_ack);
endmodule : serial_register_slave_port

// ---- logic/twowire_pkg.sv ----
// Shared constants, types and states of the two-wire register target
package twowire_pkg;
    localparam int INDEX_W = 8;
    localparam int DATA_W = 8;
    localparam logic [5:0] TARGET_ADDR_HI = 6'h34;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    localparam int CTRL_MAX_SCL_HZ = 400000;
    localparam int SPI_MAX_SCLK_HZ = 1000000;
    localparam logic DIR_READ = 1'b1;
    localparam logic DIR_WRITE = 1'b0;

    typedef struct packed {
        logic write;
        logic [INDEX_W-1:0] index;
        logic [DATA_W-1:0] data;
    } reg_req_t;

    typedef struct packed {
        logic strobe;
        logic [INDEX_W-1:0] index;
        logic [DATA_W-1:0] data;
    } reg_wr_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_RX,
        ST_ACK_RX,
        ST_WAIT,
        ST_TX,
        ST_ACK_TX,
        ST_IGNORE
    } link_state_t;

    typedef enum logic [1:0] {
        C_IDLE,
        C_READ
    } core_state_t;
endpackage : twowire_pkg

// ---- logic/reg_store.sv ----
// Register storage with one write/read port and registered read data
`timescale 1ns/1ps
module reg_store #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    // Clock
    input wire logic i_clk,
    // Access port
    input wire logic i_we,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    output logic [DATA_W-1:0] o_rdata
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule : reg_store

// ---- tb/twowire_host.sv ----
// Bus controller model for the two-wire register target
`timescale 1ns/1ps
module twowire_host (
    // Pacing clock
    input wire logic i_clk,
    // Resolved bus lines
    input wire logic i_scl_line,
    input wire logic i_sda_line,
    // Line releases, high lets the pull-up win
    output logic o_scl_rel,
    output logic o_sda_rel
);
    int lo_ext = 0;
    int glitches = 0;

    initial begin
        o_scl_rel = 1'b1;
        o_sda_rel = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge i_clk);
    endtask : wt

    // Release clock, wait while the target holds it low
    task automatic rise();
        o_scl_rel = 1'b1;
        for (int n = 0; n < 100 && i_scl_line !== 1'b1; n++) wt(1);
    endtask : rise

    // Low and high phases of 13 cycles or more keep the clock under 400 kHz
    task automatic clk_bit(input logic b, output logic s);
        o_sda_rel = b;
        wt(6 + lo_ext);
        rise();
        wt(6);
        s = i_sda_line;
        wt(7);
        if (i_sda_line !== s) glitches++;
        o_scl_rel = 1'b0;
        wt(7);
    endtask : clk_bit

    task automatic start_cond();
        o_sda_rel = 1'b1;
        wt(6);
        rise();
        wt(13);
        o_sda_rel = 1'b0;
        wt(13);
        o_scl_rel = 1'b0;
        wt(7);
    endtask : start_cond

    task automatic stop_cond();
        o_sda_rel = 1'b0;
        wt(6);
        rise();
        wt(13);
        o_sda_rel = 1'b1;
        wt(13);
    endtask : stop_cond

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
        clk_bit(1'b1, ack);
    endtask : put_byte

    task automatic get_byte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
        clk_bit(nack, s);
    endtask : get_byte
endmodule : twowire_host

// ---- tb/tb.sv ----
// Self-checking bench for the two-wire register target
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
    $display("FAIL %0t: got %h expected %h", $time, (a), (e)); end end
module tb;
    import twowire_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_link_clk = 1'b0;
    logic i_addr_lsb_strap = 1'b0;
    logic i_twowire_port_disable = 1'b0;
    logic o_scl_out, o_scl_oe, o_sda_out, o_sda_oe;
    reg_wr_t o_reg_wr;
    logic scl_rel, sda_rel, scl_line, sda_line;
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    int held = 0;
    logic [31:0] seed = 32'h10f1;
    logic [7:0] mem [256];
    logic [15:0] wq [$];

    always #50 i_clk = ~i_clk;
    initial #3 forever #6 i_link_clk = ~i_link_clk;

    assign scl_line = scl_rel & ~(o_scl_oe & ~o_scl_out);
    assign sda_line = sda_rel & ~(o_sda_oe & ~o_sda_out);

    serial_register_slave_port dut (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_link_clk(i_link_clk),
        .i_scl(scl_line),
        .o_scl_out(o_scl_out),
        .o_scl_oe(o_scl_oe),
        .i_sda(sda_line),
        .o_sda_out(o_sda_out),
        .o_sda_oe(o_sda_oe),
        .i_addr_lsb_strap(i_addr_lsb_strap),
        .i_twowire_port_disable(i_twowire_port_disable),
        .o_reg_wr(o_reg_wr)
    );

    twowire_host host (
        .i_clk(i_clk),
        .i_scl_line(scl_line),
        .i_sda_line(sda_line),
        .o_scl_rel(scl_rel),
        .o_sda_rel(sda_rel)
    );

    function automatic logic [7:0] rnd8();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd8

    function automatic logic [7:0] addr_byte(input logic strap, input logic dir);
        return {TARGET_ADDR_HI, strap, dir};
    endfunction : addr_byte

    task automatic tally_and_finish();
        if (errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    always @(negedge i_clk) begin
        cyc++;
        if (o_reg_wr.strobe === 1'b1) wq.push_back({o_reg_wr.index, o_reg_wr.data});
        if (o_scl_oe === 1'b1) held++;
        if (!i_rst) `CHK({o_scl_out, o_sda_out}, 2'h0)
        if (cyc == 60000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic wr_burst(input logic [7:0] ix, input int n);
        logic ak;
        logic [7:0] d;
        logic [15:0] got;
        host.start_cond();
        host.put_byte(addr_byte(i_addr_lsb_strap, 1'b0), ak);
        `CHK(ak, 1'b0)
        host.put_byte(ix, ak);
        `CHK(ak, 1'b0)
        for (int i = 0; i < n; i++) begin
            d = rnd8();
            mem[ix + 8'(i)] = d;
            host.put_byte(d, ak);
            `CHK(ak, 1'b0)
        end
        host.stop_cond();
        for (int i = 0; i < n; i++) begin
            got = (wq.size() > 0) ? wq.pop_front() : 16'hxxxx;
            `CHK(got, {ix + 8'(i), mem[ix + 8'(i)]})
        end
    endtask : wr_burst

    task automatic rd_burst(input logic [7:0] ix, input int n);
        logic ak;
        logic [7:0] d;
        host.start_cond();
        host.put_byte(addr_byte(i_addr_lsb_strap, 1'b0), ak);
        `CHK(ak, 1'b0)
        host.put_byte(ix, ak);
        `CHK(ak, 1'b0)
        host.start_cond();
        host.put_byte(addr_byte(i_addr_lsb_strap, 1'b1), ak);
        `CHK(ak, 1'b0)
        for (int i = 0; i < n; i++) begin
            host.get_byte(i == n - 1, d);
            `CHK(d, mem[ix + 8'(i)])
        end
        host.wt(20);
        `CHK(o_sda_oe, 1'b0)
        `CHK(o_scl_oe, 1'b0)
        host.stop_cond();
    endtask : rd_burst

    task automatic probe(input logic [7:0] ab);
        logic ak;
        host.start_cond();
        host.put_byte(ab, ak);
        `CHK(ak, 1'b1)
        host.put_byte(rnd8(), ak);
        `CHK(ak, 1'b1)
        host.stop_cond();
        `CHK(wq.size(), 0)
        `CHK(o_scl_oe, 1'b0)
    endtask : probe

    initial begin
        logic [7:0] ix;
        int n;
        repeat (10) @(negedge i_clk);
        i_rst = 1'b0;
        host.wt(5);
        for (int s = 0; s < 4; s++) begin
            i_addr_lsb_strap = s[0];
            host.lo_ext = int'(rnd8() % 8);
            ix = (s == 3) ? 8'hfd : rnd8();
            n = 1 + int'(rnd8() % 3);
            wr_burst(ix, n);
            rd_burst(ix, n);
            probe({TARGET_ADDR_HI, ~s[0], 1'b0});
            probe(rnd8() & 8'h7f);
        end
        i_twowire_port_disable = 1'b1;
        host.wt(10);
        probe(addr_byte(i_addr_lsb_strap, 1'b0));
        i_twowire_port_disable = 1'b0;
        host.wt(10);
        probe(addr_byte(i_addr_lsb_strap, 1'b0));
        `CHK(host.glitches, 0)
        `CHK(held > 0, 1'b1)
        tally_and_finish();
    end
endmodule : tb
